//--- dv/fan_thermal_config_regs_tb.sv
// Purpose: self-checking bench of the fan/thermal register bank
// Assumes: zero-wait APB, shortened tick and spin-up counts
// Notes: register table rows first, then hand-written cases
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module fan_thermal_config_regs_tb;
  typedef struct packed {
    logic [7:0] idx, rst, wd, exp;
    logic err;
  } ftcr_row_type;
  localparam ftcr_row_type ROWS [12] = '{'{8'h10, 8'h00, 8'h20, 8'h20, 1'b0},
    '{8'h78, 8'h00, 8'ha4, 8'ha4, 1'b0}, '{8'h79, 8'h00, 8'hff, 8'h00, 1'b0},
    '{8'h7a, 8'h00, 8'h03, 8'h03, 1'b0}, '{8'h7b, 8'h55, 8'h1b, 8'h1b, 1'b0},
    '{8'h7c, 8'h01, 8'h3e, 8'h3e, 1'b0}, '{8'h7d, 8'h00, 8'h81, 8'h81, 1'b0},
    '{8'h7e, 8'h00, 8'hff, 8'h00, 1'b0}, '{8'h7f, 8'h00, 8'hff, 8'h00, 1'b0},
    '{8'h46, 8'h00, 8'h40, 8'h40, 1'b0}, '{8'h42, 8'h00, 8'h0f, 8'h0f, 1'b0},
    '{8'h20, 8'h00, 8'haa, 8'h00, 1'b1}};
  localparam logic [7:0] CFGS [4] = '{8'h01, 8'h02, 8'h04, 8'h87};
  logic clock_i = 1'b0, rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, err;
  logic [7:0] core_voltage_i = 8'hff, rd;
  logic manual_mode_i = 1'b0, fan_enable_i = 1'b0;
  logic [2:0][15:0] smooth_base_i = {16'd300, 16'd200, 16'd100};
  logic thermal_limit_pin_n_i = 1'b1, processor_hot_input_n_i = 1'b1;
  logic fan_full_speed_o, fan_programmed_o, spinup_active_o;
  logic [2:0][18:0] smooth_time_o;
  logic sync_leader_enable_o, sync_follower_enable_o, irq_o, alert_o;
  logic [7:0] drive_options_o, pulse_count_o, sensor_format_o, attenuation_o;
  int n_fail = 0, check_count = 0, cycles = 0;
  logic [18:0] want;
  logic [2:0] fan_st;
  assign fan_st = {spinup_active_o, fan_full_speed_o, fan_programmed_o};

  ftcr_regs #(.TW(16), .TICK_CYCLES(4), .SPINUP_CYCLES(8)) dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .core_voltage_i(core_voltage_i), .manual_mode_i(manual_mode_i),
    .fan_enable_i(fan_enable_i), .smooth_base_i(smooth_base_i),
    .thermal_limit_pin_n_i(thermal_limit_pin_n_i),
    .processor_hot_input_n_i(processor_hot_input_n_i),
    .fan_full_speed_o(fan_full_speed_o), .fan_programmed_o(fan_programmed_o),
    .spinup_active_o(spinup_active_o), .smooth_time_o(smooth_time_o),
    .sync_leader_enable_o(sync_leader_enable_o),
    .sync_follower_enable_o(sync_follower_enable_o),
    .drive_options_o(drive_options_o), .pulse_count_o(pulse_count_o),
    .sensor_format_o(sensor_format_o), .attenuation_o(attenuation_o),
    .irq_o(irq_o), .alert_o(alert_o));

  always #20 clock_i = ~clock_i;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one-word transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic logic [18:0] scale(int b, logic slow, logic extra);
    int t;
    t = slow ? b * 4 : b;
    return 19'(extra ? t + t * 392 / 1000 : t);
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    wait_n(10);
    rst_n_i <= 1'b1;
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i].idx, 8'h00);
      `CHK(rd, ROWS[i].rst);
      apb(1'b1, ROWS[i].idx, ROWS[i].wd);
      `CHK(err, ROWS[i].err);
      apb(1'b0, ROWS[i].idx, 8'h00);
      `CHK(rd, ROWS[i].exp);
    end
    `CHK({drive_options_o, pulse_count_o, sensor_format_o, attenuation_o},
      32'ha41b3e81);
    `CHK({sync_leader_enable_o, sync_follower_enable_o}, 2'b10);
    apb(1'b1, 8'h10, 8'h10);
    wait_n(2);
    `CHK({sync_leader_enable_o, sync_follower_enable_o}, 2'b01);
    apb(1'b1, 8'h10, 8'h30);
    wait_n(2);
    `CHK({sync_leader_enable_o, sync_follower_enable_o}, 2'b10);
    foreach (CFGS[i]) begin
      apb(1'b1, 8'h10, CFGS[i]);
      wait_n(3);
      for (int c = 0; c < 3; c++) begin
        want = scale(smooth_base_i[c], CFGS[i][c], CFGS[i][7]);
        `CHK(smooth_time_o[c], want);
      end
    end
    apb(1'b1, 8'h78, 8'h00);
    apb(1'b1, 8'h10, 8'h40);
    core_voltage_i <= 8'h20;
    processor_hot_input_n_i <= 1'b0;
    wait_n(6);
    apb(1'b0, 8'h41, 8'h00);
    `CHK(rd, 8'h02);
    `CHK({irq_o, alert_o}, 2'b10);
    apb(1'b1, 8'h78, 8'h01);
    wait_n(3);
    `CHK(alert_o, 1'b1);
    apb(1'b1, 8'h41, 8'h02);
    wait_n(3);
    apb(1'b0, 8'h41, 8'h00);
    `CHK({rd, irq_o}, 9'h000);
    fan_enable_i <= 1'b1;
    core_voltage_i <= 8'h80;
    wait_n(4);
    `CHK(fan_st, 3'b110);
    wait_n(12);
    `CHK(fan_st, 3'b001);
    apb(1'b0, 8'h41, 8'h00);
    `CHK(rd, 8'h08);
    apb(1'b1, 8'h42, 8'h00);
    wait_n(2);
    `CHK(irq_o, 1'b0);
    apb(1'b1, 8'h41, 8'h08);
    processor_hot_input_n_i <= 1'b1;
    apb(1'b1, 8'h10, 8'h00);
    fan_enable_i <= 1'b0;
    thermal_limit_pin_n_i <= 1'b0;
    wait_n(6);
    `CHK(fan_full_speed_o, 1'b1);
    thermal_limit_pin_n_i <= 1'b1;
    manual_mode_i <= 1'b1;
    wait_n(6);
    thermal_limit_pin_n_i <= 1'b0;
    wait_n(6);
    `CHK(fan_full_speed_o, 1'b0);
    apb(1'b1, 8'h10, 8'h08);
    wait_n(4);
    `CHK(fan_full_speed_o, 1'b1);
    thermal_limit_pin_n_i <= 1'b1;
    manual_mode_i <= 1'b0;
    apb(1'b1, 8'h40, 8'h06);
    apb(1'b1, 8'h78, 8'h55);
    apb(1'b0, 8'h78, 8'h00);
    `CHK(rd, 8'h01);
    apb(1'b1, 8'h7a, 8'h09);
    apb(1'b0, 8'h7a, 8'h00);
    `CHK(rd, 8'h09);
    apb(1'b1, 8'h40, 8'h04);
    apb(1'b0, 8'h40, 8'h00);
    `CHK(rd, 8'h06);
    rst_n_i <= 1'b0;
    wait_n(3);
    `CHK({drive_options_o, pulse_count_o, sensor_format_o, attenuation_o},
      32'h00550100);
    rst_n_i <= 1'b1;
    apb(1'b1, 8'h78, 8'h55);
    apb(1'b0, 8'h78, 8'h00);
    `CHK(rd, 8'h55);
    complete_run();
  end
endmodule
`default_nettype wire

//--- dv/ftcr_regs_asserts.sv
// Purpose: port-level checks of the fan/thermal register bank
// Assumes: one clock domain, async active-low reset
// Notes: spin-up bound follows the bound SPINUP_CYCLES
`timescale 1ns/10ps
`default_nettype none
module ftcr_regs_asserts #(
  parameter int TW = 16,
  parameter int unsigned SPINUP_CYCLES = 8
) (
  // clock, reset, bus
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic pslverr_o,
  // monitor side
  input wire logic manual_mode_i,
  input wire logic [2:0][TW-1:0] smooth_base_i,
  input wire logic thermal_limit_pin_n_i,
  input wire logic fan_full_speed_o,
  input wire logic spinup_active_o,
  input wire logic [2:0][TW+2:0] smooth_time_o,
  // configuration outputs
  input wire logic sync_leader_enable_o,
  input wire logic sync_follower_enable_o,
  input wire logic [7:0] drive_options_o,
  input wire logic [7:0] pulse_count_o,
  input wire logic [7:0] sensor_format_o,
  input wire logic [7:0] attenuation_o,
  input wire logic alert_o
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  localparam int SPIN_MAX = SPINUP_CYCLES + 2;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_sync_roles_exclusive:
    assert property (sync_follower_enable_o |-> !sync_leader_enable_o)
    else $error("both sync roles active");
  a_alert_when_off:
    assert property (!drive_options_o[0] && $past(!drive_options_o[0])
      |-> !alert_o) else $error("alert while alerting disabled");
  a_spinup_length:
    assert property ($rose(spinup_active_o) |-> spinup_active_o[*4]
      ##[1:SPIN_MAX] !spinup_active_o) else $error("spin-up length wrong");
  a_spin_forces_full:
    assert property (spinup_active_o ##1 spinup_active_o
      |-> fan_full_speed_o) else $error("no full speed in spin-up");
  a_limit_forces_full:
    assert property (!thermal_limit_pin_n_i[*4] ##0 !manual_mode_i
      |-> ##[0:3] fan_full_speed_o) else $error("limit pin ignored");
  a_config_hold:
    assert property ($past(rst_n_i) && !$past(psel_i && penable_i && pwrite_i)
      |-> $stable({drive_options_o, pulse_count_o, sensor_format_o,
      attenuation_o, sync_leader_enable_o}))
    else $error("config changed without write");
  a_smooth_bounds:
    assert property ($past(rst_n_i) |->
      smooth_time_o[0] >= $past(smooth_base_i[0]) &&
      32'(smooth_time_o[0]) * 1000 <= 32'($past(smooth_base_i[0])) * 5568)
    else $error("smoothing time out of range");
  a_error_in_access:
    assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
endmodule
bind ftcr_regs ftcr_regs_asserts #(.TW(TW), .SPINUP_CYCLES(SPINUP_CYCLES))
  u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pslverr_o(pslverr_o),
  .manual_mode_i(manual_mode_i), .smooth_base_i(smooth_base_i),
  .thermal_limit_pin_n_i(thermal_limit_pin_n_i),
  .fan_full_speed_o(fan_full_speed_o), .spinup_active_o(spinup_active_o),
  .smooth_time_o(smooth_time_o), .sync_leader_enable_o(sync_leader_enable_o),
  .sync_follower_enable_o(sync_follower_enable_o),
  .drive_options_o(drive_options_o), .pulse_count_o(pulse_count_o),
  .sensor_format_o(sensor_format_o), .attenuation_o(attenuation_o),
  .alert_o(alert_o));
`default_nettype wire

//--- rtl/ftcr_pkg.sv
// Purpose: constants shared by the fan/thermal configuration register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: offsets are word indices; byte address = index * 4
package ftcr_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TIMER_TICK_US = 1000;
  localparam int unsigned TIMER_TICK_CYCLES =
    (CLK_HZ / 1_000_000) * TIMER_TICK_US;
  localparam int unsigned SPINUP_TIME_US = 2000;
  localparam int unsigned SPINUP_CYCLES =
    (CLK_HZ / 1_000_000) * SPINUP_TIME_US;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SMOOTH_SYNC = 8'h10;
  localparam logic [7:0] IDX_LOCK_CFG = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_MASK = 8'h42;
  localparam logic [7:0] IDX_CORE_LOW_LIMIT = 8'h46;
  localparam logic [7:0] IDX_DRIVE_OPT = 8'h78;
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h79;
  localparam logic [7:0] IDX_TIMER_LIMIT = 8'h7a;
  localparam logic [7:0] IDX_PULSE_COUNT = 8'h7b;
  localparam logic [7:0] IDX_SENSOR_FMT = 8'h7c;
  localparam logic [7:0] IDX_ATTEN_BYPASS = 8'h7d;
  localparam logic [7:0] IDX_TEST_ONE = 8'h7e;
  localparam logic [7:0] IDX_TEST_TWO = 8'h7f;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_SMOOTH_SYNC = 8'h00;
  localparam logic [7:0] RST_LOCK_CFG = 8'h04;
  localparam logic [7:0] RST_CORE_LOW_LIMIT = 8'h00;
  localparam logic [7:0] RST_DRIVE_OPT = 8'h00;
  localparam logic [7:0] RST_TIMER_LIMIT = 8'h00;
  localparam logic [7:0] RST_PULSE_COUNT = 8'h55;
  localparam logic [7:0] RST_SENSOR_FMT = 8'h01;
  localparam logic [7:0] RST_ATTEN_BYPASS = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned SLOW_R1_BIT = 0;
  localparam int unsigned SLOW_LOCAL_BIT = 1;
  localparam int unsigned SLOW_R2_BIT = 2;
  localparam int unsigned LIMIT_MANUAL_BIT = 3;
  localparam int unsigned FOLLOWER_BIT = 4;
  localparam int unsigned LEADER_BIT = 5;
  localparam int unsigned CORE_LOW_BIT = 6;
  localparam int unsigned EXTRA_SLOW_BIT = 7;
  localparam int unsigned ALERT_EN_BIT = 0;
  localparam int unsigned LOCK_BIT = 1;
  localparam int unsigned ST_THERMAL_BIT = 0;
  localparam int unsigned ST_CORE_LOW_BIT = 1;
  localparam int unsigned ST_TIMER_BIT = 2;
  localparam int unsigned ST_PROC_HOT_BIT = 3;
  localparam int unsigned ST_WIDTH = 4;

  // ----------------------------------------------------------------------
  // smoothing scale factors
  // ----------------------------------------------------------------------
  localparam int unsigned SLOW_SHIFT = 2;
  localparam logic [9:0] EXTRA_NUM = 10'd392;
  localparam int unsigned EXTRA_DEN = 1000;

endpackage

//--- rtl/ftcr_regs.sv
// Purpose: configuration/status register bank of a fan and thermal monitor
// Assumes: APB slave, zero wait states, pins are asynchronous
// Notes: status register bits are sticky and cleared by writing one
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ftcr_regs #(
  parameter int TW = 16,
  parameter int unsigned TICK_CYCLES = ftcr_pkg::TIMER_TICK_CYCLES,
  parameter int unsigned SPINUP_CYCLES = ftcr_pkg::SPINUP_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // monitor inputs from same-clock logic
  input wire logic [7:0] core_voltage_i,
  input wire logic manual_mode_i,
  input wire logic fan_enable_i,
  input wire logic [2:0][TW-1:0] smooth_base_i,
  // asynchronous pins
  input wire logic thermal_limit_pin_n_i,
  input wire logic processor_hot_input_n_i,
  // fan control outputs
  output logic fan_full_speed_o,
  output logic fan_programmed_o,
  output logic spinup_active_o,
  output logic [2:0][TW+2:0] smooth_time_o,
  // sync roles
  output logic sync_leader_enable_o,
  output logic sync_follower_enable_o,
  // configuration fields for the rest of the chip
  output logic [7:0] drive_options_o,
  output logic [7:0] pulse_count_o,
  output logic [7:0] sensor_format_o,
  output logic [7:0] attenuation_o,
  // interrupts
  output logic irq_o,
  output logic alert_o
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int SPIN_W = $clog2(SPINUP_CYCLES + 1);
  localparam int SW = ftcr_pkg::ST_WIDTH;

  typedef struct packed {
    logic [7:0] smooth_sync;
    logic [7:0] lock_cfg;
    logic [SW-1:0] status;
    logic [SW-1:0] mask;
    logic [7:0] core_low_limit;
    logic [7:0] drive_opt;
    logic [7:0] timer_limit;
    logic [7:0] pulse_count;
    logic [7:0] sensor_fmt;
    logic [7:0] atten;
    logic [6:0] timer;
    logic [TICK_W-1:0] tick_cnt;
    logic [SPIN_W-1:0] spin_cnt;
    logic [1:0] limit_sync;
    logic [1:0] hot_sync;
    logic limit_prev;
    logic hot_prev;
    logic core_low_prev;
    logic fan_full;
    logic fan_prog;
    logic irq;
    logic alert;
    logic [31:0] rdata;
  } ftcr_state_type;

  ftcr_state_type state_reg;
  ftcr_state_type state_next;

  ftcr_smooth_if #(.TW(TW)) sm_if ();

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [7:0] idx;
  logic mapped;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_acc;
  logic locked;
  logic [7:0] wbyte;

  assign idx = paddr_i[9:2];
  assign setup_ph = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wbyte = pwdata_i[7:0];

  always_comb begin
    mapped = 1'b0;
    if (paddr_i[11:10] == 2'b00 && paddr_i[1:0] == 2'b00) begin
      case (idx)
        ftcr_pkg::IDX_SMOOTH_SYNC, ftcr_pkg::IDX_LOCK_CFG,
        ftcr_pkg::IDX_STATUS, ftcr_pkg::IDX_MASK,
        ftcr_pkg::IDX_CORE_LOW_LIMIT, ftcr_pkg::IDX_DRIVE_OPT,
        ftcr_pkg::IDX_TIMER_STATUS, ftcr_pkg::IDX_TIMER_LIMIT,
        ftcr_pkg::IDX_PULSE_COUNT, ftcr_pkg::IDX_SENSOR_FMT,
        ftcr_pkg::IDX_ATTEN_BYPASS, ftcr_pkg::IDX_TEST_ONE,
        ftcr_pkg::IDX_TEST_TWO: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  assign wr_en = access_ph & pwrite_i & mapped;
  assign rd_acc = access_ph & ~pwrite_i & mapped;
  assign locked = state_reg.lock_cfg[ftcr_pkg::LOCK_BIT];

  // ----------------------------------------------------------------------
  // monitoring conditions
  // ----------------------------------------------------------------------
  logic limit_level;
  logic limit_active;
  logic core_low;
  logic hot_monitored;
  logic spinning;
  logic tick;
  logic [6:0] timer_inc;

  assign limit_level = ~state_reg.limit_sync[1];
  assign limit_active = limit_level & (~manual_mode_i |
    state_reg.smooth_sync[ftcr_pkg::LIMIT_MANUAL_BIT]);
  assign core_low = state_reg.smooth_sync[ftcr_pkg::CORE_LOW_BIT] &
    (core_voltage_i < state_reg.core_low_limit);
  assign hot_monitored = ~state_reg.hot_sync[1] & ~core_low;
  assign spinning = state_reg.spin_cnt != '0;
  assign tick = limit_active &&
    (state_reg.tick_cnt == TICK_W'(TICK_CYCLES - 1));
  assign timer_inc = (state_reg.timer == 7'h7f) ? 7'h7f :
    state_reg.timer + 7'h01;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [SW-1:0] events;
    logic [SW-1:0] clr;
    events = '0;
    clr = '0;
    state_next = state_reg;

    // pins pass two flops before use
    state_next.limit_sync = {state_reg.limit_sync[0], thermal_limit_pin_n_i};
    state_next.hot_sync = {state_reg.hot_sync[0], processor_hot_input_n_i};
    state_next.limit_prev = limit_active;
    state_next.hot_prev = hot_monitored;
    state_next.core_low_prev = core_low;

    // assert timer counts thermal-active time in ticks
    if (!limit_active || tick) begin
      state_next.tick_cnt = '0;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + TICK_W'(1);
    end
    if (rd_acc && idx == ftcr_pkg::IDX_TIMER_STATUS) begin
      // clear on read, but a tick in the same cycle still counts
      state_next.timer = tick ? 7'h01 : 7'h00;
    end else if (tick) begin
      state_next.timer = timer_inc;
    end
    if (tick && state_reg.timer_limit != 8'h00 &&
        {1'b0, timer_inc} == state_reg.timer_limit) begin
      events[ftcr_pkg::ST_TIMER_BIT] = 1'b1;
    end

    if (state_reg.core_low_prev && !core_low) begin
      state_next.spin_cnt = SPIN_W'(SPINUP_CYCLES);
    end else if (core_low) begin
      state_next.spin_cnt = '0;
    end else if (spinning) begin
      state_next.spin_cnt = state_reg.spin_cnt - SPIN_W'(1);
    end

    // thermal limit wins over any fan state
    state_next.fan_full = limit_active | (state_next.spin_cnt != '0);
    state_next.fan_prog = fan_enable_i & ~core_low & ~limit_active &
      (state_next.spin_cnt == '0);

    // events
    if (limit_active && !state_reg.limit_prev) begin
      events[ftcr_pkg::ST_THERMAL_BIT] = 1'b1;
    end
    // core low sets status bit one
    if (core_low && !state_reg.core_low_prev) begin
      events[ftcr_pkg::ST_CORE_LOW_BIT] = 1'b1;
    end
    if (hot_monitored && !state_reg.hot_prev) begin
      events[ftcr_pkg::ST_PROC_HOT_BIT] = 1'b1;
    end

    // register writes
    if (wr_en) begin
      case (idx)
        ftcr_pkg::IDX_SMOOTH_SYNC: begin
          if (!locked) begin
            state_next.smooth_sync = wbyte;
          end
        end
        ftcr_pkg::IDX_LOCK_CFG: begin
          // lock bit only sets; register frozen once set
          if (!locked) begin
            state_next.lock_cfg = wbyte;
          end
        end
        ftcr_pkg::IDX_STATUS: clr = wbyte[SW-1:0];
        ftcr_pkg::IDX_MASK: state_next.mask = wbyte[SW-1:0];
        ftcr_pkg::IDX_CORE_LOW_LIMIT: state_next.core_low_limit = wbyte;
        ftcr_pkg::IDX_DRIVE_OPT: begin
          if (!locked) begin
            state_next.drive_opt = wbyte;
          end
        end
        ftcr_pkg::IDX_TIMER_LIMIT: state_next.timer_limit = wbyte;
        ftcr_pkg::IDX_PULSE_COUNT: state_next.pulse_count = wbyte;
        ftcr_pkg::IDX_SENSOR_FMT: begin
          if (!locked) begin
            state_next.sensor_fmt = wbyte;
          end
        end
        ftcr_pkg::IDX_ATTEN_BYPASS: begin
          if (!locked) begin
            state_next.atten = wbyte;
          end
        end
        default: ;
      endcase
    end

    // sticky status: a new event beats a clear in the same cycle
    state_next.status = (state_reg.status & ~clr) | events;

    // interrupt and alert follow the updated status
    state_next.irq = |(state_next.status & state_next.mask);
    state_next.alert = state_next.irq &
      state_next.drive_opt[ftcr_pkg::ALERT_EN_BIT];

    // read data captured in the setup cycle
    if (setup_ph) begin
      state_next.rdata = 32'h0000_0000;
      case (idx)
        ftcr_pkg::IDX_SMOOTH_SYNC:
          state_next.rdata[7:0] = state_reg.smooth_sync;
        ftcr_pkg::IDX_LOCK_CFG: state_next.rdata[7:0] = state_reg.lock_cfg;
        ftcr_pkg::IDX_STATUS: state_next.rdata[SW-1:0] = state_reg.status;
        ftcr_pkg::IDX_MASK: state_next.rdata[SW-1:0] = state_reg.mask;
        ftcr_pkg::IDX_CORE_LOW_LIMIT:
          state_next.rdata[7:0] = state_reg.core_low_limit;
        ftcr_pkg::IDX_DRIVE_OPT: state_next.rdata[7:0] = state_reg.drive_opt;
        ftcr_pkg::IDX_TIMER_STATUS:
          state_next.rdata[7:0] = {state_reg.timer, limit_active};
        ftcr_pkg::IDX_TIMER_LIMIT:
          state_next.rdata[7:0] = state_reg.timer_limit;
        ftcr_pkg::IDX_PULSE_COUNT:
          state_next.rdata[7:0] = state_reg.pulse_count;
        ftcr_pkg::IDX_SENSOR_FMT:
          state_next.rdata[7:0] = state_reg.sensor_fmt;
        ftcr_pkg::IDX_ATTEN_BYPASS: state_next.rdata[7:0] = state_reg.atten;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.smooth_sync <= ftcr_pkg::RST_SMOOTH_SYNC;
      state_reg.lock_cfg <= ftcr_pkg::RST_LOCK_CFG;
      state_reg.core_low_limit <= ftcr_pkg::RST_CORE_LOW_LIMIT;
      state_reg.drive_opt <= ftcr_pkg::RST_DRIVE_OPT;
      state_reg.timer_limit <= ftcr_pkg::RST_TIMER_LIMIT;
      state_reg.pulse_count <= ftcr_pkg::RST_PULSE_COUNT;
      state_reg.sensor_fmt <= ftcr_pkg::RST_SENSOR_FMT;
      state_reg.atten <= ftcr_pkg::RST_ATTEN_BYPASS;
      // idle pin level is high, so no false event after reset
      state_reg.limit_sync <= 2'b11;
      state_reg.hot_sync <= 2'b11;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // smoothing scaler
  // ----------------------------------------------------------------------
  // per-channel slowdown bits
  assign sm_if.slow = {state_reg.smooth_sync[ftcr_pkg::SLOW_R2_BIT],
                       state_reg.smooth_sync[ftcr_pkg::SLOW_LOCAL_BIT],
                       state_reg.smooth_sync[ftcr_pkg::SLOW_R1_BIT]};
  assign sm_if.extra = state_reg.smooth_sync[ftcr_pkg::EXTRA_SLOW_BIT];
  assign sm_if.base = smooth_base_i;

  ftcr_smooth #(
    .TW(TW)
  ) u_smooth (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sm(sm_if.calc)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~mapped;
  assign prdata_o = state_reg.rdata;
  assign smooth_time_o = sm_if.scaled;
  assign fan_full_speed_o = state_reg.fan_full;
  assign fan_programmed_o = state_reg.fan_prog;
  assign spinup_active_o = spinning;
  // leader role; leader wins if both are set
  assign sync_leader_enable_o = state_reg.smooth_sync[ftcr_pkg::LEADER_BIT];
  assign sync_follower_enable_o =
    state_reg.smooth_sync[ftcr_pkg::FOLLOWER_BIT] &
    ~state_reg.smooth_sync[ftcr_pkg::LEADER_BIT];
  assign drive_options_o = state_reg.drive_opt;
  assign pulse_count_o = state_reg.pulse_count;
  assign sensor_format_o = state_reg.sensor_fmt;
  assign attenuation_o = state_reg.atten;
  assign irq_o = state_reg.irq;
  assign alert_o = state_reg.alert;

endmodule
`default_nettype wire

//--- rtl/ftcr_smooth.sv
// Purpose: scales each channel's smoothing time by the slowdown options
// Assumes: base times come from same-clock logic
// Notes: extra slowdown rounds the added fraction down
`timescale 1ns/10ps
`default_nettype none
module ftcr_smooth #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // controls and results
  ftcr_smooth_if.calc sm
);

  typedef struct packed {
    logic [2:0][TW+2:0] scaled;
  } ftcr_sm_state_type;

  ftcr_sm_state_type state_reg;
  ftcr_sm_state_type state_next;
  logic [2:0][TW+2:0] calc_w;

  // ----------------------------------------------------------------------
  // per-channel scaling
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < 3; ch++) begin : g_ch
    logic [TW+1:0] quad;
    logic [TW+11:0] prod;
    logic [TW+11:0] frac;
    assign quad = sm.slow[ch] ?
      ({2'b00, sm.base[ch]} << ftcr_pkg::SLOW_SHIFT) :
      {2'b00, sm.base[ch]};
    assign prod = {10'h000, quad} * {{(TW+2){1'b0}}, ftcr_pkg::EXTRA_NUM};
    assign frac = prod / (TW+12)'(ftcr_pkg::EXTRA_DEN);
    assign calc_w[ch] = sm.extra ?
      ({1'b0, quad} + frac[TW+2:0]) : {1'b0, quad};
  end

  always_comb begin
    state_next = state_reg;
    state_next.scaled = calc_w;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sm.scaled = state_reg.scaled;

endmodule
`default_nettype wire

//--- rtl/ftcr_smooth_if.sv
// Purpose: carries smoothing controls and scaled times between modules
// Assumes: three fan channels
// Notes: scaled times are three bits wider than the base times
`timescale 1ns/10ps
`default_nettype none
interface ftcr_smooth_if #(
  parameter int TW = 16
);
  logic [2:0] slow;
  logic extra;
  logic [2:0][TW-1:0] base;
  logic [2:0][TW+2:0] scaled;

  modport ctrl (output slow, output extra, output base, input scaled);
  modport calc (input slow, input extra, input base, output scaled);
endinterface
`default_nettype wire
